// >>> logic/tsc_defines.vh
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

// apb register byte offsets of the controller
`define TSC_OFF_CMD        8'h00
`define TSC_OFF_WDATA      8'h04
`define TSC_OFF_RDATA      8'h08
`define TSC_OFF_STAT       8'h0c
`define TSC_OFF_CTRL       8'h10

// stat register bit positions
`define TSC_STAT_BUSY      0
`define TSC_STAT_IRQ       1
`define TSC_STAT_REFUSED   2
`define TSC_STAT_TMR_SET   3
`define TSC_STAT_DONE      4

// command codes of the device
`define TSC_AC_RESET       8'h01
`define TSC_AC_CTRL        8'h30
`define TSC_AC_STATUS      8'h31
`define TSC_AC_FREQ        8'h32
`define TSC_AC_SILENCE     8'h33
`define TSC_AC_TONE1       8'h34
`define TSC_AC_TONE2       8'h35
`define TSC_AC_INTERVAL    8'h36

// device control register fields
`define TSC_CTL_AUDIO      7
`define TSC_CTL_TMR_IE     6
`define TSC_CTL_DEC_IE     5
`define TSC_CTL_SUM        4
`define TSC_CTL_BAND_HI    3
`define TSC_CTL_BAND_LO    2
`define TSC_BAND_BAD       2'b11
`define TSC_CTL_RSVD_MASK  8'hfc

// tone generator 1 word: bits 15 and 14 forced low
`define TSC_TONE1_MASK     16'h3fff

// reset values
`define TSC_RST_WORD16     16'h0000
`define TSC_RST_BYTE       8'h00

// serial clock: period in ns and half period in system clocks
`define TSC_CLK_NS         40
`define TSC_SCLK_NS        320
`define TSC_HALF_CYC       ((`TSC_SCLK_NS / `TSC_CLK_NS) / 2)
`define TSC_GAP_CYC        `TSC_HALF_CYC

`endif

// >>> logic/tsc_byte_shift.v
`timescale 1ns/1ns
`include "tsc_defines.vh"

module tsc_byte_shift #(
   parameter HALF = `TSC_HALF_CYC
) (
   input  wire       clk,
   input  wire       resetn,
   input  wire       start,
   input  wire [7:0] tx_byte,
   input  wire       reply_s,
   output reg        sclk_q,
   output reg        cmd_data_q,
   output reg        done_q,
   output reg  [7:0] rx_byte_q,
   output wire       busy
);

   reg  [7:0] tx_q;
   reg  [2:0] bit_q;
   reg  [7:0] ph_q;
   reg        act_q;

   assign busy = act_q;

   ////////////////////////////////////////////////////////////////////////
   // clock low half: data set up, high half: device samples, we sample at end
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_q       <= 8'h00;
         bit_q      <= 3'h0;
         ph_q       <= 8'h00;
         act_q      <= 1'b0;
         sclk_q     <= 1'b1;
         cmd_data_q <= 1'b0;
         done_q     <= 1'b0;
         rx_byte_q  <= 8'h00;
      end else begin
         done_q <= 1'b0;
         if (start && !act_q) begin
            act_q      <= 1'b1;
            tx_q       <= {tx_byte[6:0], 1'b0};
            cmd_data_q <= tx_byte[7];
            bit_q      <= 3'h0;
            ph_q       <= 8'h00;
            sclk_q     <= 1'b0;
         end else if (act_q) begin
            if (ph_q == HALF - 1) begin
               ph_q <= 8'h00;
               if (!sclk_q) begin
                  sclk_q <= 1'b1;
               end else begin
                  // reply sampled late in the high half so the sync delay is covered
                  rx_byte_q <= {rx_byte_q[6:0], reply_s};
                  if (bit_q == 3'h7) begin
                     act_q  <= 1'b0;
                     done_q <= 1'b1;
                  end else begin
                     sclk_q     <= 1'b0;
                     cmd_data_q <= tx_q[7];
                     tx_q       <= {tx_q[6:0], 1'b0};
                     bit_q      <= bit_q + 3'h1;
                  end
               end
            end else begin
               ph_q <= ph_q + 8'h01;
            end
         end
      end
   end

endmodule // tsc_byte_shift

// >>> logic/tsc_host.v
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "tsc_defines.vh"

// How it works
// - first byte after select is the command code, then its data or reply bytes
// - code 30h sends one byte that becomes the device control register
// - code 31h reads one reply byte of device status
// - code 32h reads two reply bytes of frequency measurement
// - code 33h sends one byte for the silence timer setting
// - codes 34h and 35h each send two bytes to tone generators
// - code 36h sends one byte for the interval timer period
// - interval timer must be written before its interrupt is enabled
// - control bits 3:2 pick band; value 11 must never be written
// - each tone generator gets its own separately laid out word
// - tone 1 word: bits 12:0 divider, bit 13 mute, bits 15:14 zero
module tsc_host #(
   parameter HALF = `TSC_HALF_CYC,
   parameter GAP  = `TSC_GAP_CYC
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire        sclk,
   output reg         cs_n_q,
   output wire        cmd_data,
   input  wire        reply_data,
   input  wire        irq_n
);

   localparam S_IDLE  = 3'd0;
   localparam S_SEL   = 3'd1;
   localparam S_WAIT  = 3'd2;
   localparam S_DESEL = 3'd3;

   reg  [2:0]  state_q;
   reg  [7:0]  cnt_q;
   reg  [7:0]  code_q;
   reg  [15:0] wdata_q;
   reg  [15:0] rdata_q;
   reg  [7:0]  ctrl_q;
   reg  [1:0]  nbytes_q;
   reg         is_read_q;
   reg  [1:0]  idx_q;
   reg         refused_q;
   reg         done_q;
   reg         tmr_set_q;
   reg         start_q;
   reg  [7:0]  tx_byte;
   reg  [1:0]  rsync_q;
   reg  [1:0]  isync_q;
   reg  [1:0]  len_d;
   reg         rd_d;
   reg         ok_d;
   reg  [15:0] word_d;

   wire        busy = (state_q != S_IDLE);
   wire        acc  = psel && penable;
   wire        wr   = acc && pwrite;
   wire        rd   = acc && !pwrite;
   wire        map  = (paddr == `TSC_OFF_CMD) || (paddr == `TSC_OFF_WDATA) || (paddr == `TSC_OFF_RDATA)
                      || (paddr == `TSC_OFF_STAT) || (paddr == `TSC_OFF_CTRL);
   wire        cmd_wr = wr && (paddr == `TSC_OFF_CMD);
   wire        bad    = !map || (cmd_wr && busy);
   wire        go     = cmd_wr && !busy && ok_d;
   wire        sh_done;
   wire [7:0]  sh_rx;
   wire        irq_s  = !isync_q[1];

   assign pready  = 1'b1;
   assign pslverr = acc && bad;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by the second
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsync_q <= 2'b00;
         isync_q <= 2'b11;
      end else begin
         rsync_q <= {rsync_q[0], reply_data};
         isync_q <= {isync_q[0], irq_n};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command decode: byte counts and host-side sanitising of the word
   always @* begin
      len_d  = 2'd0;
      rd_d   = 1'b0;
      ok_d   = 1'b1;
      word_d = wdata_q;
      case (pwdata[7:0])
         `TSC_AC_RESET: begin
            len_d = 2'd0;
         end
         `TSC_AC_CTRL: begin
            len_d  = 2'd1;
            word_d = {8'h00, wdata_q[7:0] & `TSC_CTL_RSVD_MASK};
            // band 11 is illegal; timer irq before period written would storm
            if (wdata_q[`TSC_CTL_BAND_HI:`TSC_CTL_BAND_LO] == `TSC_BAND_BAD) begin
               ok_d = 1'b0;
            end
            if (wdata_q[`TSC_CTL_TMR_IE] && !tmr_set_q) begin
               ok_d = 1'b0;
            end
         end
         `TSC_AC_STATUS: begin
            len_d = 2'd1;
            rd_d  = 1'b1;
         end
         `TSC_AC_FREQ: begin
            len_d = 2'd2;
            rd_d  = 1'b1;
         end
         `TSC_AC_SILENCE: begin
            len_d = 2'd1;
         end
         `TSC_AC_TONE1: begin
            len_d  = 2'd2;
            word_d = wdata_q & `TSC_TONE1_MASK;
         end
         `TSC_AC_TONE2: begin
            len_d = 2'd2;
         end
         `TSC_AC_INTERVAL: begin
            len_d = 2'd1;
         end
         default: begin
            ok_d = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // byte to shift for the current index: code, then high byte before low
   always @* begin
      if (idx_q == 2'd0) begin
         tx_byte = code_q;
      end else if (is_read_q) begin
         tx_byte = 8'h00;
      end else if (nbytes_q == 2'd2 && idx_q == 2'd1) begin
         tx_byte = wdata_q[15:8];
      end else begin
         tx_byte = wdata_q[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer sequencer and software registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q   <= S_IDLE;
         cnt_q     <= 8'h00;
         code_q    <= `TSC_RST_BYTE;
         wdata_q   <= `TSC_RST_WORD16;
         rdata_q   <= `TSC_RST_WORD16;
         ctrl_q    <= `TSC_RST_BYTE;
         nbytes_q  <= 2'd0;
         is_read_q <= 1'b0;
         idx_q     <= 2'd0;
         refused_q <= 1'b0;
         done_q    <= 1'b0;
         tmr_set_q <= 1'b0;
         start_q   <= 1'b0;
         cs_n_q    <= 1'b1;
      end else begin
         start_q <= 1'b0;
         if (wr && paddr == `TSC_OFF_WDATA && !busy) begin
            wdata_q <= pwdata[15:0];
         end
         // sticky flags: a new event wins over a clear in the same cycle
         if (cmd_wr && (busy || !ok_d)) begin
            refused_q <= 1'b1;
         end else if (wr && paddr == `TSC_OFF_STAT && pwdata[`TSC_STAT_REFUSED]) begin
            refused_q <= 1'b0;
         end
         if (state_q == S_DESEL && cnt_q == GAP - 1) begin
            done_q <= 1'b1;
         end else if (go || (wr && paddr == `TSC_OFF_STAT && pwdata[`TSC_STAT_DONE])) begin
            done_q <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               if (go) begin
                  code_q    <= pwdata[7:0];
                  wdata_q   <= word_d;
                  nbytes_q  <= len_d;
                  is_read_q <= rd_d;
                  idx_q     <= 2'd0;
                  cnt_q     <= 8'h00;
                  cs_n_q    <= 1'b0;
                  state_q   <= S_SEL;
                  if (rd_d) begin
                     rdata_q <= `TSC_RST_WORD16;
                  end
                  if (pwdata[7:0] == `TSC_AC_CTRL) begin
                     ctrl_q <= word_d[7:0];
                  end
                  if (pwdata[7:0] == `TSC_AC_INTERVAL) begin
                     tmr_set_q <= 1'b1;
                  end else if (pwdata[7:0] == `TSC_AC_RESET) begin
                     tmr_set_q <= 1'b0;
                     ctrl_q    <= `TSC_RST_BYTE;
                  end
               end
            end
            S_SEL: begin
               if (cnt_q == GAP - 1) begin
                  start_q <= 1'b1;
                  state_q <= S_WAIT;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            S_WAIT: begin
               if (sh_done) begin
                  if (is_read_q && idx_q != 2'd0) begin
                     rdata_q <= {rdata_q[7:0], sh_rx};
                  end
                  if (idx_q == nbytes_q) begin
                     cnt_q   <= 8'h00;
                     cs_n_q  <= 1'b1;
                     state_q <= S_DESEL;
                  end else begin
                     idx_q   <= idx_q + 2'd1;
                     start_q <= 1'b1;
                  end
               end
            end
            S_DESEL: begin
               // keep select high a while so the device sees a clean frame end
               if (cnt_q == GAP - 1) begin
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            default: begin
               state_q <= S_IDLE;
               cs_n_q  <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read mux; device status bits 0..3 arrive in rdata after a 31h read
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `TSC_OFF_CMD:   prdata = {24'h000000, code_q};
         `TSC_OFF_WDATA: prdata = {16'h0000, wdata_q};
         `TSC_OFF_RDATA: prdata = {16'h0000, rdata_q};
         `TSC_OFF_STAT:  prdata = {27'h0000000, done_q, tmr_set_q, refused_q, irq_s, busy};
         `TSC_OFF_CTRL:  prdata = {24'h000000, ctrl_q};
         default:        prdata = 32'h0000_0000;
      endcase
   end

   tsc_byte_shift #(
      .HALF (HALF)
   ) u_shift (
      .clk        (clk),
      .resetn     (resetn),
      .start      (start_q),
      .tx_byte    (tx_byte),
      .reply_s    (rsync_q[1]),
      .sclk_q     (sclk),
      .cmd_data_q (cmd_data),
      .done_q     (sh_done),
      .rx_byte_q  (sh_rx),
      .busy       ()
   );

endmodule // tsc_host

// >>> test/tsc_host_asserts.sv
`timescale 1ns/1ns
`include "tsc_defines.vh"
module tsc_host_asserts #(
   parameter HALF = `TSC_HALF_CYC,
   parameter GAP  = `TSC_GAP_CYC
) (
   input logic        clk,
   input logic        resetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic        sclk,
   input logic        cs_n_q,
   input logic        cmd_data
);
   logic [15:0] sh_q;
   logic [7:0]  code_q;
   int          nb_q;
   logic        sclk_p_q;
   logic        cs_p_q;
   wire         cmd_wr = psel && penable && pwrite && paddr == `TSC_OFF_CMD;
   function automatic int nbytes(input logic [7:0] c);
      case (c)
         `TSC_AC_CTRL, `TSC_AC_STATUS, `TSC_AC_SILENCE, `TSC_AC_INTERVAL: return 1;
         `TSC_AC_FREQ, `TSC_AC_TONE1, `TSC_AC_TONE2: return 2;
         `TSC_AC_RESET: return 0;
         default: return -1;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // wire-side shadow of each frame; edges found by hand, two-event block has no single clock
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nb_q <= 0;
         sh_q <= 16'h0000;
         code_q <= 8'h00;
         sclk_p_q <= 1'b1;
         cs_p_q <= 1'b1;
      end else begin
         sclk_p_q <= sclk;
         cs_p_q <= cs_n_q;
         if (cs_p_q && !cs_n_q) begin
            nb_q <= 0;
         end else if (!cs_n_q && sclk && !sclk_p_q) begin
            sh_q <= {sh_q[14:0], cmd_data};
            nb_q <= nb_q + 1;
            if (nb_q == 7) code_q <= {sh_q[6:0], cmd_data};
         end
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////
   // half periods hard-wired for the default HALF of 4
   sclk_idle_a: assert property (cs_n_q |-> sclk) else $error("sclk low outside frame");
   fall_in_frame_a: assert property ($fell(sclk) |-> !cs_n_q) else $error("sclk edge without select");
   bit_edge_a: assert property (!sclk && $changed(cmd_data) |-> $fell(sclk)) else $error("data moved in low half");
   low_half_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk) else $error("low half length");
   high_half_a: assert property ($rose(sclk) |-> sclk [*4]) else $error("high half length");
   frame_bits_a: assert property ($rose(cs_n_q) |-> nb_q == 8 * (1 + nbytes(code_q)))
      else $error("frame bit count wrong");
   ctrl_word_a: assert property ($rose(cs_n_q) && code_q == `TSC_AC_CTRL
      |-> sh_q[3:2] != `TSC_BAND_BAD && sh_q[1:0] == 2'b00) else $error("bad control byte sent");
   tone_word_a: assert property ($rose(cs_n_q) && code_q == `TSC_AC_TONE1 |-> sh_q[15:14] == 2'b00)
      else $error("tone word top bits set");
   unknown_code_a: assert property (cs_n_q [*6] ##0 (cmd_wr && nbytes(pwdata[7:0]) < 0) |-> ##1 cs_n_q [*8])
      else $error("frame for unknown code");
   cover property ($rose(cs_n_q) && code_q == `TSC_AC_FREQ);
   cover property ($rose(cs_n_q) && code_q == `TSC_AC_TONE1);
   cover property ($rose(cs_n_q) && code_q == `TSC_AC_STATUS);
endmodule // tsc_host_asserts

bind tsc_host tsc_host_asserts #(.HALF(HALF), .GAP(GAP)) u_chk (.clk(clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sclk(sclk), .cs_n_q(cs_n_q),
   .cmd_data(cmd_data));

// >>> test/tsc_dev_model.sv
`timescale 1ns/1ns
module tsc_dev_model (
   input  logic sclk,
   input  logic cs_n,
   input  logic cmd_data,
   input  logic gp_in,
   output logic reply_data,
   output logic irq_n
);
   logic [7:0]  ctrl_q = 0, st_q = 0, sil_q = 0, gpt_q = 0, code_q = 0;
   logic [15:0] freq_q = 0, tone1_q = 0, tone2_q = 0, sin_q = 0, sout_q = 0;
   logic        last_q = 0;
   int          nb_q = 0;
   // zero period expires without end, so bit 2 stays up
   wire [7:0]   status = {4'h0, gp_in, st_q[2] | (gpt_q == 0), st_q[1:0]};
   wire         audio_on = ctrl_q[7];
   wire         sum_on = ctrl_q[4];
   wire [1:0]   band = ctrl_q[3:2];
   wire         tone1_mute = tone1_q[13];
   wire         tone1_save = tone1_q[12:0] == 0;
   assign irq_n = !((ctrl_q[6] && status[2]) || (ctrl_q[5] && |status[1:0]));
   // released line shows the inverse of the last bit, never a stale copy
   assign reply_data = cs_n ? !last_q : last_q;
   task fire(input int b);
      st_q[b] = 1'b1;
   endtask
   always @(negedge cs_n) nb_q = 0;
   always @(posedge sclk) begin
      if (!cs_n) begin
         sin_q = {sin_q[14:0], cmd_data};
         nb_q++;
         if (nb_q == 8) code_q = sin_q[7:0];
         if (nb_q == 8 && code_q == 8'h01) begin
            gpt_q = 0;
            st_q = 0;
            ctrl_q = 0;
         end
         if (nb_q == 8 && code_q == 8'h31) begin
            sout_q = {status, 8'h00};
            st_q = 0;
         end
         if (nb_q == 8 && code_q == 8'h32) sout_q = freq_q;
         if (nb_q == 16 && code_q == 8'h30) ctrl_q = sin_q[7:0];
         if (nb_q == 16 && code_q == 8'h33) begin
            sil_q = sin_q[7:0];
            st_q[1] = 0;
         end
         if (nb_q == 16 && code_q == 8'h36) begin
            gpt_q = sin_q[7:0];
            st_q[2] = 0;
         end
         if (nb_q == 24 && code_q == 8'h34) tone1_q = sin_q;
         if (nb_q == 24 && code_q == 8'h35) tone2_q = sin_q;
      end
   end
   always @(negedge sclk) begin
      if (!cs_n && nb_q >= 8) begin
         last_q = sout_q[15];
         sout_q = {sout_q[14:0], 1'b0};
      end
   end
endmodule // tsc_dev_model

// >>> test/testbench.sv
`timescale 1ns/1ns
`include "tsc_defines.vh"
module testbench;
   logic        clk, resetn, psel, penable, pwrite, gp_in, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, sclk, cs_n_q, cmd_data, reply_data, irq_n;
   int          err_count, num_checks;
   tsc_host u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n_q(cs_n_q),
      .cmd_data(cmd_data), .reply_data(reply_data), .irq_n(irq_n));
   tsc_dev_model u_dev (.sclk(sclk), .cs_n(cs_n_q), .cmd_data(cmd_data), .gp_in(gp_in),
      .reply_data(reply_data), .irq_n(irq_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("errors %0d checks %0d", err_count, num_checks);
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one idle edge first, so psel is never assigned twice in a time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) err_count++;
      if (n >= 100) close_out;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic idle;
      int n;
      n = 0;
      do begin
         apb(0, `TSC_OFF_STAT, 0);
         n++;
      end while (rd[`TSC_STAT_BUSY] !== 1'b0 && n < 300);
      if (n >= 300) err_count++;
      if (n >= 300) close_out;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [15:0] w);
      apb(1, `TSC_OFF_WDATA, {16'h0000, w});
      apb(1, `TSC_OFF_CMD, {24'h000000, c});
      idle;
   endtask
   task automatic st(input logic [7:0] e);
      cmd(`TSC_AC_STATUS, 16'h0000);
      apb(0, `TSC_OFF_RDATA, 0);
      chk(rd, {24'h000000, e});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic s_refuse;
      apb(0, 8'h14, 0);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      cmd(8'h37, 16'h0000);
      chk(rd[`TSC_STAT_REFUSED], 1'b1);
      apb(1, `TSC_OFF_CMD, `TSC_AC_STATUS);
      apb(1, `TSC_OFF_CMD, `TSC_AC_STATUS);
      chk(er, 1'b1);
      idle;
      chk(rd[`TSC_STAT_DONE], 1'b1);
      apb(0, `TSC_OFF_CMD, 0);
      chk(rd, 32'h00000031);
   endtask
   task automatic s_reset;
      cmd(`TSC_AC_RESET, 16'h0000);
      st(8'h0c);
      // refused is sticky from the earlier scenario: clear it so this check can trip
      apb(1, `TSC_OFF_STAT, 32'h4);
      cmd(`TSC_AC_CTRL, 16'h0040);
      chk({rd[`TSC_STAT_REFUSED], u_dev.ctrl_q}, 9'h100);
      apb(1, `TSC_OFF_STAT, 32'h4);
   endtask
   task automatic s_ctrl;
      logic [7:0] v [4] = '{8'h80, 8'h44, 8'h28, 8'hd3};
      cmd(`TSC_AC_INTERVAL, 16'h0005);
      chk(u_dev.gpt_q, 8'h05);
      st(8'h08);
      foreach (v[i]) begin
         cmd(`TSC_AC_CTRL, {8'h00, v[i]});
         chk(u_dev.ctrl_q, v[i] & 8'hfc);
      end
      cmd(`TSC_AC_CTRL, 16'h000c);
      chk(u_dev.ctrl_q, 8'hd0);
      apb(0, `TSC_OFF_CTRL, 0);
      chk(rd, 32'h000000d0);
   endtask
   task automatic s_status;
      u_dev.fire(2);
      repeat (4) @(posedge clk);
      apb(0, `TSC_OFF_STAT, 0);
      chk(rd[`TSC_STAT_IRQ], 1'b1);
      cmd(`TSC_AC_CTRL, 16'h0000);
      u_dev.fire(0);
      u_dev.fire(1);
      repeat (4) @(posedge clk);
      apb(0, `TSC_OFF_STAT, 0);
      chk(rd[`TSC_STAT_IRQ], 1'b0);
      st(8'h0f);
      st(8'h08);
      gp_in <= 0;
      u_dev.fire(0);
      u_dev.fire(1);
      u_dev.fire(2);
      cmd(`TSC_AC_SILENCE, 16'h0007);
      chk(u_dev.sil_q, 8'h07);
      cmd(`TSC_AC_INTERVAL, 16'h0009);
      st(8'h01);
   endtask
   task automatic s_data;
      u_dev.freq_q = 16'ha55a;
      cmd(`TSC_AC_FREQ, 16'h0000);
      apb(0, `TSC_OFF_RDATA, 0);
      chk(rd, 32'h0000a55a);
      cmd(`TSC_AC_TONE1, 16'hf2a5);
      chk(u_dev.tone1_q, 16'h32a5);
      apb(0, `TSC_OFF_WDATA, 0);
      chk(rd, 32'h000032a5);
      cmd(`TSC_AC_TONE2, 16'hc3c3);
      chk(u_dev.tone2_q, 16'hc3c3);
   endtask
   // mid-run reset: timer-programmed memory must be lost, so timer irq enable is refused again
   task automatic s_rerun;
      resetn <= 0;
      repeat (3) @(posedge clk);
      resetn <= 1;
      apb(0, `TSC_OFF_STAT, 0);
      chk(rd, 32'h0);
      apb(0, `TSC_OFF_CTRL, 0);
      chk(rd, 32'h0);
      cmd(`TSC_AC_CTRL, 16'h0040);
      chk(rd[`TSC_STAT_REFUSED], 1'b1);
      chk(u_dev.ctrl_q, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      close_out;
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      gp_in = 1'b1;
      err_count = 0;
      num_checks = 0;
      repeat (20) @(posedge clk);
      resetn <= 1;
      s_refuse;
      s_reset;
      s_ctrl;
      s_status;
      s_data;
      s_rerun;
      close_out;
   end
endmodule // testbench
